// file: ssf_flag_bank.sv
// What this block does
// RULE1: every flag has a setter class; system flags also carry their update occasion
// RULE2: system flags update on exactly one occasion from the fixed occasion list
// RULE3: initial-class values are taken only during start-up, never while running
// RULE4: diagnostic error latch sets on a diagnosed error and stays set
// RULE5: self-diagnostic error latch sets on a self-diagnosed error and stays set
// RULE6: falling motion error flag after review re-latches both diagnostic latches
// RULE7: latched battery-low sets below the low threshold and stays set
// RULE8: live battery-low follows the low-threshold comparison, updated on error
// RULE9: latched battery-warning sets below the warning threshold and stays set
// RULE10: live battery-warning follows the warning-threshold comparison
// RULE11: supply dip within the limit sets a flag only a power cycle clears
// RULE12: blown-fuse latch sets when any output module reports a blown fuse
// RULE13: on request the clock error flag reflects validity of the time words
// RULE14: one bus-ready flag per CPU, updated on status change
// RULE15: first-CPU resetting flag high while in reset or module removed
// RULE16: while the first CPU resets, all other CPUs are held in reset
// RULE17: user-only flags carry no update occasion
// RULE18: all flags are readable at any time with no side effect
// RULE19: latched flags clear only on power-on or controller reset
`timescale 1ns/10ps
`include "ssf_cfg.svh"

module ssf_flag_bank #(
	parameter int DIP_LONG_CYC  = `SSF_DIP_LONG_MS * `SSF_CLK_KHZ,
	parameter int DIP_SHORT_CYC = `SSF_DIP_SHORT_MS * `SSF_CLK_KHZ
) (
	// clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	// axi4-lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// diagnosis inputs
	input  wire logic        diag_fault,
	input  wire logic        self_diag_fault,
	input  wire logic        motion_error_detect_flag,
	input  wire logic        nonstop_error_reviewed,
	// battery and supply monitors
	input  wire logic        batt_below_low,
	input  wire logic        batt_below_warn,
	input  wire logic        ac_supply_used,
	input  wire logic        dip_variant_short,
	input  wire logic        supply_ok,
	input  wire logic        fuse_blown_any,
	// multi-cpu bus status
	input  wire logic [3:0]  cpu_bus_ready_in,
	input  wire logic        cpu1_reset_in,
	input  wire logic        cpu1_removed,
	// flag and system outputs
	output logic [15:0]      flag_bits,
	output logic [2:0]       other_cpu_reset_hold,
	output logic             irq
);

	// ----------------------------------------
	// state and helpers
	// ----------------------------------------
	ssf_pkg::ssf_state_t s;
	ssf_pkg::ssf_state_t n;
	// s holds, n is next
	// helpers are never registered

	logic        motion_fall;
	logic [22:0] dip_limit;
	logic        time_ok;
	logic [7:0]  irq_ev;
	logic [7:0]  irq_clr;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        wr_hit;

	// bcd byte within lo..hi; bcd order matches hex order so plain compares work
	function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		logic digits_ok;
		// a nibble above 9 fails
		digits_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9);
		return digits_ok && (v >= lo) && (v <= hi);
	endfunction : bcd_in

	// merge a write into a word under byte strobes
	// lanes 2 and 3 are dropped
	function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
		logic [15:0] r;
		r = old;
		if (st[0]) begin
			r[7:0] = d[7:0];
		end
		if (st[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction : lane16

	// ----------------------------------------
	// time word validation
	// ----------------------------------------
	// a check only on request,
	// so half-writes raise nothing
	// year/month, day/hour, minute/second, weekday; upper byte of the last word must be zero
	always_comb begin
		time_ok = bcd_in(s.time_w[0][7:0], `SSF_BCD_ZERO, `SSF_BCD_YEAR_MAX)
			&& bcd_in(s.time_w[0][15:8], `SSF_BCD_ONE, `SSF_BCD_MON_MAX)
			&& bcd_in(s.time_w[1][7:0], `SSF_BCD_ONE, `SSF_BCD_DAY_MAX)
			&& bcd_in(s.time_w[1][15:8], `SSF_BCD_ZERO, `SSF_BCD_HOUR_MAX)
			&& bcd_in(s.time_w[2][7:0], `SSF_BCD_ZERO, `SSF_BCD_MIN_MAX)
			&& bcd_in(s.time_w[2][15:8], `SSF_BCD_ZERO, `SSF_BCD_MIN_MAX)
			&& bcd_in(s.time_w[3][7:0], `SSF_BCD_ZERO, `SSF_BCD_WDAY_MAX)
			&& (s.time_w[3][15:8] == `SSF_BCD_ZERO);
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	// reads only look; no register changes on a read
	// address seen while arvalid
	// unmapped reads give zero
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			`SSF_OFS_FLAGS:    rd_word[15:0] = s.flags;                   // see RULE18
			`SSF_OFS_IRQ_ST:   rd_word[7:0]  = s.irq_st;
			`SSF_OFS_IRQ_MASK: rd_word[7:0]  = s.irq_mask;
			`SSF_OFS_CTRL:     rd_word[`SSF_CTRL_CHK] = s.chk_req;
			`SSF_OFS_TIME0:    rd_word[15:0] = s.time_w[0];
			`SSF_OFS_TIME1:    rd_word[15:0] = s.time_w[1];
			`SSF_OFS_TIME2:    rd_word[15:0] = s.time_w[2];
			`SSF_OFS_TIME3:    rd_word[15:0] = s.time_w[3];
			`SSF_OFS_SETTER:   rd_word = `SSF_SETTER_WORD;                 // see RULE1
			`SSF_OFS_OCC_LO:   rd_word = `SSF_OCC_LO_WORD;                 // see RULE2
			`SSF_OFS_OCC_HI:   rd_word = `SSF_OCC_HI_WORD;                 // see RULE17
			default:           rd_hit  = 1'b0;
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// later steps win a field
	// fields not named hold
	always_comb begin
		n           = s;
		irq_clr     = 8'h00;
		irq_ev      = 8'h00;
		wr_hit      = 1'b1;
		motion_fall = s.motion_prev & ~motion_error_detect_flag;
		// strap taken at start-up
		dip_limit   = s.short_dip ? 23'(DIP_SHORT_CYC) : 23'(DIP_LONG_CYC);

		// reset low like the pin,
		// so no false fall
		n.motion_prev = motion_error_detect_flag;

		// start-up captures the supply straps; they stay frozen while running
		unique case (s.phase)
			ssf_pkg::PH_INIT: begin
				// flags stay zero here
				n.ac_mode   = ac_supply_used;                                // see RULE3
				n.short_dip = dip_variant_short;                             // see RULE3
				n.init_cnt  = s.init_cnt + 4'h1;
				if (s.init_cnt == `SSF_INIT_LAST) begin
					n.phase = ssf_pkg::PH_RUN;
				end
			end
			ssf_pkg::PH_RUN: begin
				// pins show one edge later
				// unreviewed errors and stop
				// errors leave latches alone
				// error-class latches: only set here, only reset clears them
				if (diag_fault || (motion_fall && nonstop_error_reviewed)) begin
					n.flags[`SSF_F_DIAG] = 1'b1;                             // see RULE4, RULE6, RULE19
				end
				if (self_diag_fault || (motion_fall && nonstop_error_reviewed)) begin
					n.flags[`SSF_F_SELF] = 1'b1;                             // see RULE5, RULE6
				end
				if (batt_below_low) begin
					n.flags[`SSF_F_BLOW_L] = 1'b1;                           // see RULE7
				end
				n.flags[`SSF_F_BLOW_V] = batt_below_low;                     // see RULE8
				if (batt_below_warn) begin
					n.flags[`SSF_F_BWARN_L] = 1'b1;                          // see RULE9
				end
				n.flags[`SSF_F_BWARN_V] = batt_below_warn;                   // see RULE10
				if (fuse_blown_any) begin
					n.flags[`SSF_F_FUSE] = 1'b1;                             // see RULE12
				end

				// dc supply: no dip flag
				// a dip cut by reset is lost
				// dip timer counts the outage and saturates one past the limit
				if (s.ac_mode) begin
					if (!supply_ok) begin
						if (s.dip_cnt <= dip_limit) begin
							n.dip_cnt = s.dip_cnt + 23'h000001;
						end
					end else begin
						if ((s.dip_cnt != 23'h000000) && (s.dip_cnt <= dip_limit)) begin
							n.flags[`SSF_F_DIP] = 1'b1;                      // see RULE11
						end
						// supply back: end count
						// zero count: no outage
						n.dip_cnt = 23'h000000;
					end
				end

				// clock check runs only when software asks for it
				// request bit self-clears
				// a new request wins
				if (s.chk_req) begin
					n.flags[`SSF_F_CLKERR] = ~time_ok;                       // see RULE13
					n.chk_req              = 1'b0;
				end

				// status-change class: follow the bus and reset status
				// one cycle behind the pins; the peer
				// hold below takes the next flag, so
				// both leave on one edge and agree
				// removal holds the peers too
				n.flags[`SSF_F_RDY_HI:`SSF_F_RDY_LO] = cpu_bus_ready_in;    // see RULE14
				n.flags[`SSF_F_CPU1RST] = cpu1_reset_in | cpu1_removed;      // see RULE15
			end
		endcase
		n.peer_rst = {3{n.flags[`SSF_F_CPU1RST]}};                          // see RULE16

		// interrupt events are rising edges of the flags that matter
		// live flags: no events
		irq_ev[`SSF_I_DIAG]    = n.flags[`SSF_F_DIAG] & ~s.flags[`SSF_F_DIAG];
		irq_ev[`SSF_I_SELF]    = n.flags[`SSF_F_SELF] & ~s.flags[`SSF_F_SELF];
		irq_ev[`SSF_I_BLOW]    = n.flags[`SSF_F_BLOW_L] & ~s.flags[`SSF_F_BLOW_L];
		irq_ev[`SSF_I_BWARN]   = n.flags[`SSF_F_BWARN_L] & ~s.flags[`SSF_F_BWARN_L];
		irq_ev[`SSF_I_DIP]     = n.flags[`SSF_F_DIP] & ~s.flags[`SSF_F_DIP];
		irq_ev[`SSF_I_FUSE]    = n.flags[`SSF_F_FUSE] & ~s.flags[`SSF_F_FUSE];
		irq_ev[`SSF_I_CLKERR]  = n.flags[`SSF_F_CLKERR] & ~s.flags[`SSF_F_CLKERR];
		irq_ev[`SSF_I_CPU1RST] = n.flags[`SSF_F_CPU1RST] & ~s.flags[`SSF_F_CPU1RST];

		// items move on valid&ready
		// answers retire on ready
		// write response retires first so a new write can follow
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end

		// address and data may arrive in either order
		if (s_axi_awvalid && s.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end

		// perform the write one cycle after both halves are held
		// held halves keep decode
		// off the pins, one cycle
		// flags and tables drop it
		if (s.aw_got && s.w_got && !s.bvalid) begin
			unique case (s.awaddr)
				`SSF_OFS_IRQ_ST: begin
					if (s.wstrb[0]) begin
						irq_clr = s.wdata[7:0];
					end
				end
				`SSF_OFS_IRQ_MASK: begin
					if (s.wstrb[0]) begin
						n.irq_mask = s.wdata[7:0];
					end
				end
				`SSF_OFS_CTRL: begin
					// a zero does nothing
					if (s.wstrb[0] && s.wdata[`SSF_CTRL_CHK]) begin
						n.chk_req = 1'b1;                                    // see RULE13
					end
				end
				// lanes 0 and 1 only
				`SSF_OFS_TIME0: n.time_w[0] = lane16(s.time_w[0], s.wdata, s.wstrb);
				`SSF_OFS_TIME1: n.time_w[1] = lane16(s.time_w[1], s.wdata, s.wstrb);
				`SSF_OFS_TIME2: n.time_w[2] = lane16(s.time_w[2], s.wdata, s.wstrb);
				`SSF_OFS_TIME3: n.time_w[3] = lane16(s.time_w[3], s.wdata, s.wstrb);
				// flags and class tables ignore writes but still answer okay
				`SSF_OFS_FLAGS, `SSF_OFS_SETTER, `SSF_OFS_OCC_LO, `SSF_OFS_OCC_HI: wr_hit = 1'b1;
				default: wr_hit = 1'b0;
			endcase
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			// unmapped: error answer
			n.bresp  = wr_hit ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
		end

		// sticky status: a new event wins over a clear in the same cycle
		// written zeros do nothing
		for (int i = 0; i < 8; i++) begin
			n.irq_st[i] = (s.irq_st[i] & ~irq_clr[i]) | irq_ev[i];
		end
		// rises with its status
		n.irq_out = |(n.irq_st & n.irq_mask);

		// read answers on the cycle after the address is taken
		// rdata frozen meanwhile
		if (s_axi_arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rdata  = rd_word;
			n.rresp  = rd_hit ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
		end

		// readies are registered, so they are worked out from the next state
		// no ready while an item
		// is held: one op each way
		n.awready = ~n.aw_got & ~n.bvalid;
		n.wready  = ~n.w_got & ~n.bvalid;
		n.arready = ~n.rvalid;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// reset clears every flag; the enable freezes everything, bus included
	// hazard: handshakes with
	// ce low are lost
	// reset works even if ce is low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;                                                         // see RULE19
		end else if (ce) begin
			s <= n;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// all outputs are fields of the state register
	// no decode after the reg
	assign s_axi_awready        = s.awready;
	assign s_axi_wready         = s.wready;
	assign s_axi_bvalid         = s.bvalid;
	assign s_axi_bresp          = s.bresp;
	assign s_axi_arready        = s.arready;
	assign s_axi_rvalid         = s.rvalid;
	assign s_axi_rdata          = s.rdata;
	assign s_axi_rresp          = s.rresp;
	assign flag_bits            = s.flags;
	assign other_cpu_reset_hold = s.peer_rst;
	assign irq                  = s.irq_out;

endmodule : ssf_flag_bank

// file: ssf_cfg.svh
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define SSF_CLK_KHZ       200000
`define SSF_DIP_LONG_MS   20
`define SSF_DIP_SHORT_MS  10
`define SSF_INIT_LAST     4'h7

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SSF_OFS_FLAGS     8'h00
`define SSF_OFS_IRQ_ST    8'h04
`define SSF_OFS_IRQ_MASK  8'h08
`define SSF_OFS_CTRL      8'h0C
`define SSF_OFS_TIME0     8'h10
`define SSF_OFS_TIME1     8'h14
`define SSF_OFS_TIME2     8'h18
`define SSF_OFS_TIME3     8'h1C
`define SSF_OFS_SETTER    8'h20
`define SSF_OFS_OCC_LO    8'h24
`define SSF_OFS_OCC_HI    8'h28

// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define SSF_F_DIAG        0
`define SSF_F_SELF        1
`define SSF_F_BLOW_L      2
`define SSF_F_BLOW_V      3
`define SSF_F_DIP         4
`define SSF_F_BWARN_L     5
`define SSF_F_BWARN_V     6
`define SSF_F_FUSE        7
`define SSF_F_CLKERR      8
`define SSF_F_RDY_LO      9
`define SSF_F_RDY_HI      12
`define SSF_F_CPU1RST     13

// ----------------------------------------
// interrupt bit positions and the control request bit
// ----------------------------------------
`define SSF_I_DIAG        0
`define SSF_I_SELF        1
`define SSF_I_BLOW        2
`define SSF_I_BWARN       3
`define SSF_I_DIP         4
`define SSF_I_FUSE        5
`define SSF_I_CLKERR      6
`define SSF_I_CPU1RST     7
`define SSF_CTRL_CHK      0

// ----------------------------------------
// constant class tables and misc values
// ----------------------------------------
`define SSF_SETTER_WORD   32'h05555555
`define SSF_OCC_LO_WORD   32'h44444444
`define SSF_OCC_HI_WORD   32'h00333335
`define SSF_RESP_OKAY     2'h0
`define SSF_RESP_SLVERR   2'h2
`define SSF_BCD_ZERO      8'h00
`define SSF_BCD_ONE       8'h01
`define SSF_BCD_YEAR_MAX  8'h99
`define SSF_BCD_MON_MAX   8'h12
`define SSF_BCD_DAY_MAX   8'h31
`define SSF_BCD_HOUR_MAX  8'h23
`define SSF_BCD_MIN_MAX   8'h59
`define SSF_BCD_WDAY_MAX  8'h06

`endif

// file: ssf_pkg.sv
package ssf_pkg;

	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef enum logic [0:0] {PH_INIT, PH_RUN} ssf_phase_t;

	typedef struct packed {
		ssf_phase_t        phase;
		logic [3:0]        init_cnt;
		logic              ac_mode;
		logic              short_dip;
		logic              motion_prev;
		logic [22:0]       dip_cnt;
		logic [15:0]       flags;
		logic              chk_req;
		logic [2:0]        peer_rst;
		logic [7:0]        irq_st;
		logic [7:0]        irq_mask;
		logic              irq_out;
		logic [3:0][15:0]  time_w;
		logic              aw_got;
		logic              w_got;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} ssf_state_t;

endpackage : ssf_pkg

// file: ssf_flag_bank_props.sv
`timescale 1ns/10ps
module ssf_props (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// read handshake
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	// monitor inputs
	input wire logic        diag_fault,
	input wire logic        self_diag_fault,
	input wire logic        motion_error_detect_flag,
	input wire logic        nonstop_error_reviewed,
	input wire logic        batt_below_low,
	input wire logic        batt_below_warn,
	input wire logic        fuse_blown_any,
	input wire logic [3:0]  cpu_bus_ready_in,
	input wire logic        cpu1_reset_in,
	input wire logic        cpu1_removed,
	// flag outputs
	input wire logic [15:0] flag_bits,
	input wire logic [2:0]  other_cpu_reset_hold
);
	// edges since reset release; inputs are hidden while start-up runs
	logic [3:0] run_cnt_reg;
	logic       run;
	always_ff @(posedge aclk) begin
		if (!aresetn) run_cnt_reg <= 4'h0;
		else if (run_cnt_reg != 4'hF) run_cnt_reg <= run_cnt_reg + 4'h1;
	end
	assign run = (run_cnt_reg > 4'hB);

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------
	// flag, peer hold and read answer behaviour
	// ----------------------------------------
	sequence s_motion_fall;
		run && $fell(motion_error_detect_flag) && nonstop_error_reviewed;
	endsequence
	sequence s_both_diag;
		flag_bits[0] && flag_bits[1];
	endsequence

	a_init_flags_quiet: assert property (run_cnt_reg < 4'h8 |-> flag_bits == 16'h0000)
		else $error("flags changed during start-up");
	a_low_live_follow: assert property (run |=> flag_bits[3] == $past(batt_below_low))
		else $error("live battery low wrong");
	a_low_latch_hold: assert property (run && (batt_below_low || flag_bits[2]) |=> flag_bits[2])
		else $error("battery low latch lost");
	a_warn_live_follow: assert property (run |=> flag_bits[6] == $past(batt_below_warn))
		else $error("live battery warning wrong");
	a_warn_latch_hold: assert property (run && (batt_below_warn || flag_bits[5]) |=> flag_bits[5])
		else $error("battery warning latch lost");
	a_diag_latch_hold: assert property (run && (diag_fault || flag_bits[0]) |=> flag_bits[0])
		else $error("diagnostic latch lost");
	a_self_latch_hold: assert property (run && (self_diag_fault || flag_bits[1]) |=> flag_bits[1])
		else $error("self diagnostic latch lost");
	a_fuse_latch_hold: assert property (run && (fuse_blown_any || flag_bits[7]) |=> flag_bits[7])
		else $error("fuse latch lost");
	a_motion_sets_diag: assert property (s_motion_fall |=> s_both_diag)
		else $error("motion flag fall did not latch");
	a_ready_follow: assert property (run |=> flag_bits[12:9] == $past(cpu_bus_ready_in))
		else $error("bus ready flags wrong");
	a_cpu1_reset_flag: assert property (run |=>
		flag_bits[13] == ($past(cpu1_reset_in) || $past(cpu1_removed))) else $error("cpu1 reset flag wrong");
	a_peer_hold_mirror: assert property (other_cpu_reset_hold == {3{flag_bits[13]}})
		else $error("peer reset hold wrong");
	a_read_answer_due: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule : ssf_props

bind ssf_flag_bank ssf_props u_props (.*);

// file: ssf_peer_model.sv
`timescale 1ns/10ps
module ssf_peer_model (
	// bench commands
	input wire logic [3:0] peer_up,
	input wire logic       cpu1_rst_cmd,
	// device side
	input wire logic [2:0] other_cpu_reset_hold,
	output logic [3:0]     cpu_bus_ready_in,
	output logic           cpu1_reset_in
);
	// a cpu held in reset cannot serve the bus, so its ready drops with the hold
	assign cpu1_reset_in    = cpu1_rst_cmd;
	assign cpu_bus_ready_in = peer_up & ~{other_cpu_reset_hold, cpu1_rst_cmd};
endmodule : ssf_peer_model

// file: ssf_flag_bank_test.sv
`timescale 1ns/10ps
`include "ssf_cfg.svh"
module ssf_flag_bank_test;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        aclk, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu1_reset_in;
	logic        aresetn = 1'b0, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, diag_fault = 1'b0, self_diag_fault = 1'b0;
	logic        motion_error_detect_flag = 1'b0, nonstop_error_reviewed = 1'b0, batt_below_low = 1'b1;
	logic        batt_below_warn = 1'b0, ac_supply_used = 1'b1, dip_variant_short = 1'b0, supply_ok = 1'b1;
	logic        fuse_blown_any = 1'b0, cpu1_removed = 1'b0, cpu1_rst_cmd = 1'b0;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, other_cpu_reset_hold;
	logic [3:0]  s_axi_wstrb = 4'hF, peer_up = 4'h0, cpu_bus_ready_in;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, n;
	logic [31:0] tw[4] = '{32'h1299, 32'h2331, 32'h5959, 32'h0006};
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] flag_bits;
	logic [33:0] rq[$], mq[$];
	logic [1:0]  wq[$];
	int          miscompares = 0, checks = 0, i;

	ssf_flag_bank #(.DIP_LONG_CYC(40), .DIP_SHORT_CYC(20)) DUT (.*);
	ssf_peer_model u_peer (.*);

	// 200 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic hang;
		miscompares++;
		$display("unexpected bus wait: expected answer seen none");
		tally_and_finish();
	endtask : hang

	task automatic cmp(input string nm, input logic [33:0] seen, input logic [33:0] exp, input logic [33:0] m);
		checks++;
		if ((seen & m) !== (exp & m)) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, exp & m, seen & m);
		end
	endtask : cmp

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		wq.push_back(r);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (k = 0; k < 50 && !(s_axi_bvalid && s_axi_bready); k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (k >= 50) hang();
	endtask : wr

	// read: the expected word goes on the queue before the request
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
		int k;
		rq.push_back({r, d});
		mq.push_back({2'h3, m});
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (k = 0; k < 50 && !(s_axi_rvalid && s_axi_rready); k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (k >= 50) hang();
	endtask : rd

	task automatic fl(input logic [15:0] v, input logic [15:0] m);
		rd(`SSF_OFS_FLAGS, {16'h0, v}, {16'h0, m}, `SSF_RESP_OKAY);
	endtask : fl

	task automatic reset_dut(input logic sh);
		@(posedge aclk);
		dip_variant_short <= sh;
		aresetn           <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : reset_dut

	// outage of c cycles on the supply monitor
	task automatic dip(input int c);
		supply_ok <= 1'b0;
		repeat (c) @(posedge aclk);
		supply_ok <= 1'b1;
	endtask : dip

	// answers taken off the bus are matched with the oldest note
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0) cmp("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front(), mq.pop_front());
		if (s_axi_bvalid && s_axi_bready && wq.size() > 0) cmp("bresp", {32'h0, s_axi_bresp}, {32'h0, wq.pop_front()}, 34'h3);
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		n = $urandom(31);
		reset_dut(1'b0);
		fl(16'h0000, 16'hFFFF);
		repeat (12) @(posedge aclk);
		fl(16'h000C, 16'h000C);
		batt_below_low <= 1'b0;
		fl(16'h0004, 16'h000C);
		// class tables, an unmapped place and a write to the read-only flags
		rd(`SSF_OFS_SETTER, `SSF_SETTER_WORD, '1, `SSF_RESP_OKAY);
		rd(`SSF_OFS_OCC_LO, `SSF_OCC_LO_WORD, '1, `SSF_RESP_OKAY);
		rd(`SSF_OFS_OCC_HI, `SSF_OCC_HI_WORD, '1, `SSF_RESP_OKAY);
		wr(8'h30, 32'h1, `SSF_RESP_SLVERR);
		rd(8'h30, 32'h0, '1, `SSF_RESP_SLVERR);
		wr(`SSF_OFS_FLAGS, 32'hFFFF, `SSF_RESP_OKAY);
		fl(16'h0004, 16'hFFFF);
		// pending status stays silent while masked, then clears on a written one
		rd(`SSF_OFS_IRQ_MASK, 32'h0, '1, `SSF_RESP_OKAY);
		rd(`SSF_OFS_IRQ_ST, 32'h04, 32'hFF, `SSF_RESP_OKAY);
		cmp("irq", {33'h0, irq}, 34'h0, 34'h1);
		wr(`SSF_OFS_IRQ_MASK, 32'hFF, `SSF_RESP_OKAY);
		cmp("irq", {33'h0, irq}, 34'h1, 34'h1);
		wr(`SSF_OFS_IRQ_ST, 32'h04, `SSF_RESP_OKAY);
		cmp("irq", {33'h0, irq}, 34'h0, 34'h1);
		diag_fault <= 1'b1;
		@(posedge aclk);
		diag_fault <= 1'b0;
		fl(16'h0005, 16'h00FF);
		cmp("irq", {33'h0, irq}, 34'h1, 34'h1);
		// one-cycle faults latch, the live warning follows its level
		{self_diag_fault, fuse_blown_any, batt_below_warn} <= 3'h7;
		@(posedge aclk);
		{self_diag_fault, fuse_blown_any} <= 2'h0;
		fl(16'h00E7, 16'h00FF);
		batt_below_warn <= 1'b0;
		fl(16'h00A7, 16'h00FF);
		wr(`SSF_OFS_IRQ_ST, 32'hFF, `SSF_RESP_OKAY);
		cmp("irq", {33'h0, irq}, 34'h0, 34'h1);
		// peers come up at random, then a first-cpu reset drags them all down
		peer_up <= n[3:0];
		fl({3'h0, n[3:0], 9'h0}, 16'h3E00);
		cpu1_rst_cmd <= 1'b1;
		repeat (3) @(posedge aclk);
		fl(16'h2000, 16'h3E00);
		cmp("hold", {31'h0, other_cpu_reset_hold}, 34'h7, 34'h7);
		cpu1_rst_cmd <= 1'b0;
		cpu1_removed <= 1'b1;
		repeat (3) @(posedge aclk);
		fl(16'h2000, 16'h2000);
		cpu1_removed <= 1'b0;
		repeat (3) @(posedge aclk);
		fl({3'h0, n[3:0], 9'h0}, 16'h3E00);
		// zeroed time words are invalid, a full valid calendar clears the error
		wr(`SSF_OFS_CTRL, 32'h1, `SSF_RESP_OKAY);
		fl(16'h0100, 16'h0100);
		for (i = 0; i < 4; i++) wr(`SSF_OFS_TIME0 + 8'(4 * i), tw[i], `SSF_RESP_OKAY);
		wr(`SSF_OFS_CTRL, 32'h1, `SSF_RESP_OKAY);
		fl(16'h0000, 16'h0100);
		// an outage one cycle past the long limit is no dip, a shorter one is
		dip(41);
		fl(16'h0000, 16'h0010);
		dip(1 + $urandom_range(39));
		fl(16'h0010, 16'h0010);
		reset_dut(1'b1);
		repeat (12) @(posedge aclk);
		fl(16'h0000, 16'h01FF);
		// straps moved while running are ignored
		{ac_supply_used, dip_variant_short} <= 2'h0;
		dip(21);
		fl(16'h0000, 16'h0010);
		dip(20);
		fl(16'h0010, 16'h0010);
		// a reviewed non-stop error whose motion flag falls sets both diagnostic latches
		{motion_error_detect_flag, nonstop_error_reviewed} <= 2'h3;
		repeat (2) @(posedge aclk);
		motion_error_detect_flag <= 1'b0;
		fl(16'h0003, 16'h0003);
		// restarted on a dc supply, an outage is no dip
		reset_dut(1'b0);
		repeat (12) @(posedge aclk);
		dip(5);
		fl(16'h0000, 16'h0010);
		tally_and_finish();
	end
endmodule : ssf_flag_bank_test
